// *** hdl/pdc_counter.sv ***
// Pulse/direction counter front end with filtering and reset policies.
// Assumes record_start is a one-cycle pulse on clk; pins are async.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"

module pdc_counter (
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic sig_pin, // Count signal pin
  input wire logic rst_pin, // External reset pin
  input wire logic dir_pin, // Direction pin
  input wire logic bidir, // 1: bi-directional counting
  input wire pdc_pkg::pdc_fw_e fw_sel, // Minimum pulse width
  input wire pdc_pkg::pdc_rst_mode_e rst_mode, // Reset policy
  input wire logic rst_invert, // 1: reset line active low
  input wire logic sw_clear, // Software reset command pulse
  input wire logic record_start, // Recording begins pulse
  output logic [`PDC_CNT_W-1:0] count, // Counter value
  output logic armed // First-pulse reset still pending
);
  import pdc_pkg::*;

  // ****************************************************************
  // Filter width decode
  // ****************************************************************
  function automatic logic [`PDC_FW_W-1:0] fw_cycles(input pdc_fw_e s);
    case (s)
      PDC_FW_100NS: fw_cycles = 8'(`PDC_CYC(`PDC_FILT_100NS));
      PDC_FW_200NS: fw_cycles = 8'(`PDC_CYC(`PDC_FILT_200NS));
      PDC_FW_500NS: fw_cycles = 8'(`PDC_CYC(`PDC_FILT_500NS));
      PDC_FW_1US: fw_cycles = 8'(`PDC_CYC(`PDC_FILT_1US_NS));
      PDC_FW_2US: fw_cycles = 8'(`PDC_CYC(`PDC_FILT_2US_NS));
      PDC_FW_5US: fw_cycles = 8'(`PDC_CYC(`PDC_FILT_5US_NS));
      default: fw_cycles = 8'(`PDC_CYC(`PDC_FILT_100NS));
    endcase
  endfunction : fw_cycles

  wire logic [`PDC_FW_W-1:0] sig_cyc = fw_cycles(fw_sel);
  // Reset and direction only need the pin synchroniser, one stable cycle
  wire logic [`PDC_FW_W-1:0] one_cyc = 8'h01;

  logic sig_f;
  logic rst_f;
  logic dir_f;
  logic sig_prev;
  logic rst_prev;
  logic [`PDC_FW_W-1:0] sig_hi_run;
  logic [`PDC_FW_W-1:0] sig_lo_run;

  // Level sensitive reset with optional inversion
  wire logic rst_active = rst_f ^ rst_invert;

  // ****************************************************************
  // Input conditioning: three lines, each synchronised
  // ****************************************************************
  pdc_glitch_filter u_sig (.clk(clk), .rst(rst), .pin(sig_pin), .min_cyc(sig_cyc),
    .level(sig_f));
  pdc_glitch_filter u_rst (.clk(clk), .rst(rst), .pin(rst_pin), .min_cyc(one_cyc),
    .level(rst_f));
  pdc_glitch_filter u_dir (.clk(clk), .rst(rst), .pin(dir_pin), .min_cyc(one_cyc),
    .level(dir_f));

  // Edge history of filtered lines
  always_ff @(posedge clk) begin
    if (rst) begin
      sig_prev <= 1'b0;
      rst_prev <= 1'b0;
    end else begin
      sig_prev <= sig_f;
      rst_prev <= rst_active;
    end
  end

  // ****************************************************************
  // Decode of events
  // ****************************************************************
  // Rise of the active level; only first-pulse mode listens to it
  wire logic rst_rise = rst_active && !rst_prev;
  // 4 MHz at 100 ns pulses leaves several cycles per edge
  wire logic count_edge = sig_f && !sig_prev;
  // Direction taken at the counting edge; ignored when uni-directional
  wire logic step_down = bidir && dir_f;
  wire logic clr_start = (rst_mode == PDC_RST_START) && record_start;
  wire logic clr_first = (rst_mode == PDC_RST_FIRST) && armed && rst_rise;
  // Held level keeps the counter at zero while active
  wire logic clr_each = (rst_mode == PDC_RST_EACH) && rst_active;
  // Software clear honoured in every policy; manual has no pin clear
  wire logic do_clear = sw_clear || clr_start || clr_first || clr_each;
  wire logic [`PDC_CNT_W-1:0] next_count = step_down ? count - 32'h1 : count + 32'h1;

  // ****************************************************************
  // Counter and first-pulse arming
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= `PDC_CNT_RESET;
    end else if (do_clear) begin
      count <= `PDC_CNT_RESET;
    end else if (count_edge) begin
      count <= next_count;
    end
  end

  // Armed at each recording start, disarmed by the first reset pulse in first-pulse mode
  always_ff @(posedge clk) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (record_start) begin
      armed <= 1'b1;
    end else if (clr_first) begin
      armed <= 1'b0;
    end
  end

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  // High runs of the synchronised count line; saturate so long levels never wrap
  always_ff @(posedge clk) begin
    if (rst || !u_sig.s3) begin
      sig_hi_run <= 8'h00;
    end else if (sig_hi_run != 8'hff) begin
      sig_hi_run <= sig_hi_run + 8'h01;
    end
  end

  // Low runs of the same line, for the gap check
  always_ff @(posedge clk) begin
    if (rst || u_sig.s3) begin
      sig_lo_run <= 8'h00;
    end else if (sig_lo_run != 8'hff) begin
      sig_lo_run <= sig_lo_run + 8'h01;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_up_step: assert property (@(posedge clk) disable iff (rst)
    (count_edge && !do_clear && !step_down) |=> count == $past(count) + 32'h1)
    else $error("count did not increment");
  chk_down_step: assert property (@(posedge clk) disable iff (rst)
    (count_edge && !do_clear && step_down) |=> count == $past(count) - 32'h1)
    else $error("count did not decrement");
  chk_uni_dir: assert property (@(posedge clk) disable iff (rst)
    (count_edge && !do_clear && !bidir) |=> count == $past(count) + 32'h1)
    else $error("direction used in uni mode");
  chk_manual_pin: assert property (@(posedge clk) disable iff (rst)
    (rst_mode == PDC_RST_MANUAL && !sw_clear && !count_edge) |=> count == $past(count))
    else $error("manual mode changed count");
  chk_start_zero: assert property (@(posedge clk) disable iff (rst)
    (rst_mode == PDC_RST_START && record_start) |=> count == 32'h0)
    else $error("start did not clear");
  chk_first_once: assert property (@(posedge clk) disable iff (rst)
    (rst_mode == PDC_RST_FIRST && armed && rst_rise && !record_start)
      |=> (count == 32'h0) && !armed)
    else $error("first pulse handling wrong");
  chk_first_ignore: assert property (@(posedge clk) disable iff (rst)
    (rst_mode == PDC_RST_FIRST && !armed && !sw_clear && !record_start && !count_edge)
      |=> count == $past(count))
    else $error("later reset not ignored");
  chk_each_zero: assert property (@(posedge clk) disable iff (rst)
    (rst_mode == PDC_RST_EACH && rst_active) |=> count == 32'h0)
    else $error("each pulse did not clear");
  chk_sw_clear: assert property (@(posedge clk) disable iff (rst)
    sw_clear |=> count == 32'h0)
    else $error("software clear ignored");
  // Filter timing, measured on the synchronised count line
  chk_short_drop: assert property (@(posedge clk) disable iff (rst)
    $rose(sig_f) |-> sig_hi_run >= sig_cyc - 8'h01)
    else $error("short pulse passed");
  chk_short_gap: assert property (@(posedge clk) disable iff (rst)
    $fell(sig_f) |-> sig_lo_run >= sig_cyc - 8'h01)
    else $error("short gap passed");
  // Direction and stepping
  chk_dir_sample: assert property (@(posedge clk) disable iff (rst)
    (count_edge && !do_clear && bidir)
      |=> count == $past(count) + ($past(dir_f) ? 32'hffff_ffff : 32'h0000_0001))
    else $error("direction not taken at the edge");
  chk_edge_once: assert property (@(posedge clk) disable iff (rst)
    count_edge |=> !count_edge)
    else $error("one edge counted twice");
  chk_hold_idle: assert property (@(posedge clk) disable iff (rst)
    (!count_edge && !do_clear) |=> $stable(count))
    else $error("count moved without an edge");
  // Policies and arming
  chk_start_only: assert property (@(posedge clk) disable iff (rst)
    (rst_mode == PDC_RST_START && !record_start && !sw_clear && !count_edge)
      |=> $stable(count))
    else $error("start mode cleared off the start");
  chk_each_idle: assert property (@(posedge clk) disable iff (rst)
    (rst_mode == PDC_RST_EACH && !rst_active && !sw_clear && !count_edge)
      |=> $stable(count))
    else $error("each mode cleared without reset");
  chk_arm_set: assert property (@(posedge clk) disable iff (rst)
    record_start |=> armed)
    else $error("recording start did not arm");
  chk_arm_hold: assert property (@(posedge clk) disable iff (rst)
    (!record_start && !clr_first) |=> $stable(armed))
    else $error("armed moved on its own");

  // Main scenarios reached by the bench
  cov_up: cover property (@(posedge clk) count_edge && !step_down);
  cov_down: cover property (@(posedge clk) count_edge && step_down);
  cov_first: cover property (@(posedge clk) clr_first);
  cov_each: cover property (@(posedge clk) clr_each);
  cov_start: cover property (@(posedge clk) clr_start);

endmodule : pdc_counter
`default_nettype wire

// *** hdl/pdc_params.svh ***
// Constants for the pulse/direction counter front end.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define PDC_CLK_PERIOD_NS 40
`define PDC_FILT_100NS 100
`define PDC_FILT_200NS 200
`define PDC_FILT_500NS 500
`define PDC_FILT_1US_NS 1000
`define PDC_FILT_2US_NS 2000
`define PDC_FILT_5US_NS 5000
// Least widths round up to whole cycles
`define PDC_CYC(ns) (((ns) + `PDC_CLK_PERIOD_NS - 1) / `PDC_CLK_PERIOD_NS)
`define PDC_CNT_W 32
`define PDC_FW_W 8
`define PDC_CNT_RESET 32'h0000_0000

`endif

// *** hdl/pdc_pkg.sv ***
// Types for the pulse/direction counter front end.
// Assumes nothing beyond a SystemVerilog compiler.
package pdc_pkg;

  // ****************************************************************
  // Reset policies and filter settings
  // ****************************************************************
  typedef enum logic [1:0] {
    PDC_RST_MANUAL,
    PDC_RST_START,
    PDC_RST_FIRST,
    PDC_RST_EACH
  } pdc_rst_mode_e;

  typedef enum logic [2:0] {
    PDC_FW_100NS,
    PDC_FW_200NS,
    PDC_FW_500NS,
    PDC_FW_1US,
    PDC_FW_2US,
    PDC_FW_5US
  } pdc_fw_e;

endpackage : pdc_pkg

// *** hdl/pdc_glitch_filter.sv ***
// Pin synchroniser plus minimum-pulse-width filter for one input line.
// Assumes the pin is asynchronous to clk; width is in clk cycles.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"

module pdc_glitch_filter (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic pin, // Raw asynchronous pin
  input wire logic [`PDC_FW_W-1:0] min_cyc, // Required stable cycles
  output logic level // Filtered level
);

  logic s1;
  logic s2;
  logic s3;
  logic [`PDC_FW_W-1:0] run;

  // ****************************************************************
  // Three-stage synchroniser; change counts when s2 and s3 agree
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  wire logic agree = (s2 == s3);
  wire logic differs = agree && (s3 != level);

  // Pulse shorter than the setting never reaches the count; the agreement
  // test eats one cycle, so N-1 differing cycles mean N cycles at the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      run <= 8'h00;
      level <= 1'b0;
    end else if (!differs) begin
      run <= 8'h00;
    end else if (run + 8'h02 >= min_cyc) begin
      level <= s3;
      run <= 8'h00;
    end else begin
      run <= run + 8'h01;
    end
  end

endmodule : pdc_glitch_filter
`default_nettype wire

// *** test/pdc_src.sv ***
// Model of the external source: count signal, reset and direction lines.
// Assumes one bench process calls its tasks; all moves follow clk rises.
`timescale 1ns/1ps
`default_nettype none

module pdc_src (
  input wire logic clk, // Bench clock
  output logic sig_pin, // Count signal
  output logic rst_pin, // External reset line
  output logic dir_pin // Direction line
);
  // ****************************************************************
  // Source behaviour
  // ****************************************************************
  // Lines start idle and low
  initial begin
    sig_pin = 1'b0;
    rst_pin = 1'b0;
    dir_pin = 1'b0;
  end

  // One count pulse; direction is left alone for its whole span
  task automatic pulse(input int hi, input int lo);
    @(posedge clk);
    sig_pin <= 1'b1;
    repeat (hi) @(posedge clk);
    sig_pin <= 1'b0;
    repeat (lo - 1) @(posedge clk);
  endtask : pulse

  // Direction moves only between pulses, then settles
  task automatic set_dir(input logic d);
    @(posedge clk);
    dir_pin <= d;
    repeat (6) @(posedge clk);
  endtask : set_dir

  // Level reset pulse at the given active level
  task automatic rst_pulse(input logic act, input int wid);
    @(posedge clk);
    rst_pin <= act;
    repeat (wid) @(posedge clk);
    rst_pin <= ~act;
    repeat (8) @(posedge clk);
  endtask : rst_pulse

  // Park the reset line at a level, for inverted polarity runs
  task automatic set_rst(input logic v);
    @(posedge clk);
    rst_pin <= v;
  endtask : set_rst
endmodule : pdc_src

`default_nettype wire

// *** test/tb_pulse_direction_counter_input.sv ***
// Self-checking bench for the pulse/direction counter front end.
// Assumes pdc_src drives the pins; the design carries its own assertions.
`timescale 1ns/1ps
`default_nettype none

module tb_pulse_direction_counter_input;
  import pdc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bidir = 1'b0;
  logic rst_invert = 1'b0;
  logic sw_clear = 1'b0;
  logic record_start = 1'b0;
  pdc_fw_e fw_sel = PDC_FW_100NS;
  pdc_rst_mode_e rst_mode = PDC_RST_MANUAL;
  logic sig_pin, rst_pin, dir_pin, armed;
  logic [31:0] count;
  logic [31:0] exp = 32'h0;
  logic [7:0] lf = 8'h62;
  int failures = 0;
  int samples_checked = 0;
  int w;
  bit cur_bidir, cur_dir;

  // 40 ns clock
  always #20 clk = ~clk;

  pdc_src i_pdc_src (.clk(clk), .sig_pin(sig_pin), .rst_pin(rst_pin), .dir_pin(dir_pin));
  pdc_counter i_pdc_counter (.clk(clk), .rst(rst), .sig_pin(sig_pin), .rst_pin(rst_pin),
    .dir_pin(dir_pin), .bidir(bidir), .fw_sel(fw_sel), .rst_mode(rst_mode),
    .rst_invert(rst_invert), .sw_clear(sw_clear), .record_start(record_start),
    .count(count), .armed(armed));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  // Filter setting in whole clock cycles, rounded up
  function automatic int fw_cyc(input int f);
    int ns;
    ns = (f == 0) ? 100 : (f == 1) ? 200 : (f == 2) ? 500 :
         (f == 3) ? 1000 : (f == 4) ? 2000 : 5000;
    return (ns + 39) / 40;
  endfunction : fw_cyc

  // Compare at the falling edge, away from the design's updates
  task automatic check(input logic [31:0] want, input bit arm_too, input logic arm_want);
    @(negedge clk);
    samples_checked++;
    if (count !== want || (arm_too && armed !== arm_want)) begin
      failures++;
      $display("MISMATCH t=%0t got=%h/%h exp=%h/%h", $time, count, armed, want, arm_want);
    end
  endtask : check

  task automatic cfg(input bit b, input bit d, input int f);
    @(posedge clk);
    bidir <= b;
    fw_sel <= pdc_fw_e'(f[2:0]);
    cur_bidir = b;
    cur_dir = d;
    w = fw_cyc(f) + 2;
    i_pdc_src.set_dir(d);
  endtask : cfg

  // Counted pulses; down only when bi-directional with direction high
  task automatic run(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      i_pdc_src.pulse(hi, lo);
      exp = exp + ((cur_bidir && cur_dir) ? 32'hffff_ffff : 32'h1);
    end
    repeat (4) @(posedge clk);
  endtask : run

  // One-cycle control strobe: 1 start of recording, 0 software clear
  task automatic ctl(input bit start, input pdc_rst_mode_e m);
    @(posedge clk);
    rst_mode <= m;
    if (start) record_start <= 1'b1;
    else sw_clear <= 1'b1;
    @(posedge clk);
    record_start <= 1'b0;
    sw_clear <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ctl

  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Random coupling, direction and filter runs
    for (int r = 0; r < 8; r++) begin
      lf = lfsr(lf);
      cfg(lf[0], lf[1], int'(lf[3:2]));
      run(int'(lf[6:4]) + 1, w, w);
      check(exp, 0, 0);
    end
    // Corners: bi-directional down, then up with a changed direction
    cfg(1'b1, 1'b1, 0);
    run(4, w, w);
    check(exp, 0, 0);
    cfg(1'b1, 1'b0, 1);
    run(2, w, w);
    check(exp, 0, 0);
    // Each filter: pulses one cycle short are dropped, full ones count
    for (int f = 0; f < 6; f++) begin
      cfg(1'b0, 1'b1, f);
      repeat (2) i_pdc_src.pulse(w - 3, w);
      check(exp, 0, 0);
      run(2, w, w);
      check(exp, 0, 0);
    end
    cfg(1'b0, 1'b0, 0);
    run(10, 3, 4);
    check(exp, 0, 0);
    // Manual: reset line ignored, software clear honoured
    ctl(1'b1, PDC_RST_MANUAL);
    i_pdc_src.rst_pulse(1'b1, 6);
    check(exp, 0, 0);
    ctl(1'b0, PDC_RST_MANUAL);
    exp = 32'h0;
    check(exp, 0, 0);
    // Start of recording loads zero
    run(3, w, w);
    ctl(1'b1, PDC_RST_START);
    exp = 32'h0;
    check(exp, 0, 0);
    // First pulse clears once, later pulses ignored
    run(3, w, w);
    ctl(1'b1, PDC_RST_FIRST);
    check(exp, 1, 1'b1);
    run(2, w, w);
    i_pdc_src.rst_pulse(1'b1, 6);
    exp = 32'h0;
    check(exp, 1, 1'b0);
    run(3, w, w);
    i_pdc_src.rst_pulse(1'b1, 6);
    check(exp, 0, 0);
    // Every pulse clears, plain then inverted level
    @(posedge clk);
    rst_mode <= PDC_RST_EACH;
    for (int k = 0; k < 2; k++) begin
      run(3, w, w);
      i_pdc_src.rst_pulse(1'b1, 6);
      exp = 32'h0;
      check(exp, 0, 0);
    end
    @(posedge clk);
    rst_invert <= 1'b1;
    i_pdc_src.set_rst(1'b1);
    repeat (10) @(posedge clk);
    run(3, w, w);
    check(exp, 0, 0);
    i_pdc_src.rst_pulse(1'b0, 6);
    exp = 32'h0;
    check(exp, 0, 0);
    results();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    results();
  end
endmodule : tb_pulse_direction_counter_input

`default_nettype wire
